// File: src/srb_defs.svh
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH

// ==========================================================
// Register offsets in the special register space
`define SRB_A_PORT0 8'h80
`define SRB_A_STACK 8'h81
`define SRB_A_BANK0_LO 8'h82
`define SRB_A_BANK0_HI 8'h83
`define SRB_A_BANK1_LO 8'h84
`define SRB_A_BANK1_HI 8'h85
`define SRB_A_POWER 8'h87
`define SRB_A_TCTRL 8'h88
`define SRB_A_TMODE 8'h89
`define SRB_A_TZ_LO 8'h8A
`define SRB_A_TO_LO 8'h8B
`define SRB_A_TZ_HI 8'h8C
`define SRB_A_TO_HI 8'h8D
`define SRB_A_AUX 8'h8E
`define SRB_A_PORT1 8'h90
`define SRB_A_SCTRL 8'h98
`define SRB_A_SERIAL_BUFFER 8'h99
`define SRB_A_PORT2 8'hA0
`define SRB_A_AUX_ONE 8'hA2
`define SRB_A_WD_RESTART 8'hA6
`define SRB_A_INT_EN 8'hA8
`define SRB_A_PORT3 8'hB0
`define SRB_A_INT_PRI 8'hB8
`define SRB_A_T2_CTRL 8'hC8
`define SRB_A_T2_MODE 8'hC9
`define SRB_A_T2_CAP_LO 8'hCA
`define SRB_A_T2_CAP_HI 8'hCB
`define SRB_A_T2_CNT_LO 8'hCC
`define SRB_A_T2_CNT_HI 8'hCD
`define SRB_A_STATUSW 8'hD0
`define SRB_A_ACCUM 8'hE0
`define SRB_A_SECOND 8'hF0
`define SRB_A_EVT_STATUS 8'hF8
`define SRB_A_EVT_MASK 8'hF9

// ==========================================================
// Reset values and field layout
`define SRB_RST_PORT 8'hFF
`define SRB_RST_STACK 8'h07
`define SRB_RST_ZERO 8'h00
`define SRB_POWER_MASK 8'h8F
`define SRB_T2_MODE_MASK 8'h03
`define SRB_B_POWER_OFF 4
`define SRB_B_BANK_SEL 0
`define SRB_B_UPDOWN 0
`define SRB_B_SER_MODE13 6
`define SRB_B_EN_TMR2 5
`define SRB_S_OVF 0
`define SRB_S_EXT 1
`define SRB_NEVT 2
`define SRB_NPLAIN 23
`define SRB_MCYC_DIV 12
`define SRB_CNT_MAX 16'hFFFF

`endif

// File: src/srb_pkg.sv
package srb_pkg;

   // Third timer control byte, bit 7 first.
   typedef struct packed {
      logic ovf_flag;
      logic ext_flag;
      logic rx_clk_sel;
      logic tx_clk_sel;
      logic ext_en;
      logic run;
      logic cnt_sel;
      logic cap_sel;
   } srb_timer_two_control_t;

   // Result of decoding an address into the plain register file.
   typedef struct packed {
      logic hit;
      logic [4:0] idx;
   } srb_hit_t;

   // Events reported by the third timer.
   typedef struct packed {
      logic ovf;
      logic ext;
   } srb_t2evt_t;

endpackage : srb_pkg

// File: src/srb_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defs.svh"

module srb_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin side
   input wire logic [W-1:0] pin_i,
   // Logic side
   output logic [W-1:0] fall_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Pins idle high, so reset to ones to avoid a false edge after release.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign fall_o = s3_q & ~s2_q;

endmodule : srb_sync
`default_nettype wire

// File: src/srb_timer2.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defs.svh"

module srb_timer2 (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control and count sources
   input wire srb_pkg::srb_timer_two_control_t cfg_i,
   input wire logic mcyc_tick_i,
   input wire logic cnt_fall_i,
   input wire logic trig_fall_i,
   // Register writes
   input wire logic wr_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   // State and events
   output logic [15:0] count_o,
   output logic [15:0] reload_o,
   output srb_pkg::srb_t2evt_t evt_o
);

   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] rcap_q;
   logic [15:0] rcap_d;

   wire logic baud = cfg_i.rx_clk_sel | cfg_i.tx_clk_sel;
   wire logic tick = cfg_i.run & (cfg_i.cnt_sel ? cnt_fall_i : mcyc_tick_i);
   wire logic ovf = tick & (count_q == `SRB_CNT_MAX);
   wire logic trig = cfg_i.ext_en & ~baud & trig_fall_i;
   wire logic capture = trig & cfg_i.cap_sel;
   wire logic reload = (ovf & (baud | ~cfg_i.cap_sel)) | (trig & ~cfg_i.cap_sel);
   wire logic wr_cl = wr_i & (addr_i == `SRB_A_T2_CNT_LO);
   wire logic wr_ch = wr_i & (addr_i == `SRB_A_T2_CNT_HI);
   wire logic wr_rl = wr_i & (addr_i == `SRB_A_T2_CAP_LO);
   wire logic wr_rh = wr_i & (addr_i == `SRB_A_T2_CAP_HI);

   // A software write to the count outranks counting in the same cycle.
   always_comb
   begin
      count_d = count_q;
      if (reload)
         count_d = rcap_q;
      else if (tick)
         count_d = count_q + 16'h0001;
      if (wr_cl)
         count_d[7:0] = wdata_i;
      if (wr_ch)
         count_d[15:8] = wdata_i;
      rcap_d = capture ? count_q : rcap_q;
      if (wr_rl)
         rcap_d[7:0] = wdata_i;
      if (wr_rh)
         rcap_d[15:8] = wdata_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count_q <= 16'h0000;
         rcap_q <= 16'h0000;
      end
      else
      begin
         count_q <= count_d;
         rcap_q <= rcap_d;
      end
   end

   assign count_o = count_q;
   assign reload_o = rcap_q;
   assign evt_o.ovf = ovf;
   assign evt_o.ext = trig;

endmodule : srb_timer2
`default_nettype wire

// File: src/srb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defs.svh"

module srb_top #(
   parameter int MCYC_DIV = `SRB_MCYC_DIV
) (
   // Clock and resets
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic por_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Core side
   input wire logic pointer_inc_i,
   input wire logic timer_one_ovf_i,
   output logic [15:0] pointer_o,
   output logic [31:0] port_latch_o,
   output logic [7:0] int_enable_o,
   output logic [7:0] int_priority_o,
   output logic power_off_flag_o,
   // Third timer pins
   input wire logic timer_two_count_input_i,
   input wire logic timer_two_trigger_input_i,
   // Serial baud ticks
   output logic rx_baud_tick_o,
   output logic tx_baud_tick_o,
   // Interrupts
   output logic timer_two_irq_o,
   output logic irq_o
);

   // ==========================================================
   // Plain register file layout

   localparam logic [7:0] PLAIN_ADDR [`SRB_NPLAIN] = '{
      `SRB_A_PORT0, `SRB_A_STACK, `SRB_A_BANK0_LO, `SRB_A_BANK0_HI,
      `SRB_A_BANK1_LO, `SRB_A_BANK1_HI, `SRB_A_TCTRL, `SRB_A_TMODE,
      `SRB_A_TZ_LO, `SRB_A_TO_LO, `SRB_A_TZ_HI, `SRB_A_TO_HI,
      `SRB_A_AUX, `SRB_A_PORT1, `SRB_A_SCTRL, `SRB_A_SERIAL_BUFFER,
      `SRB_A_PORT2, `SRB_A_INT_EN, `SRB_A_PORT3, `SRB_A_INT_PRI,
      `SRB_A_STATUSW, `SRB_A_ACCUM, `SRB_A_SECOND
   };

   // Maps an address onto a slot of the plain register file.
   function automatic srb_pkg::srb_hit_t find_plain(input logic [7:0] a);
      srb_pkg::srb_hit_t r;
      r = '0;
      for (int i = 0; i < `SRB_NPLAIN; i++)
      begin
         if (PLAIN_ADDR[i] == a)
         begin
            r.hit = 1'b1;
            r.idx = 5'(i);
         end
      end
      return r;
   endfunction : find_plain

   // Reset value of a plain register, chosen by its address.
   function automatic logic [7:0] plain_reset(input logic [7:0] a);
      logic [7:0] v;
      v = `SRB_RST_ZERO;
      if (a == `SRB_A_PORT0 || a == `SRB_A_PORT1 || a == `SRB_A_PORT2 || a == `SRB_A_PORT3)
         v = `SRB_RST_PORT;
      else if (a == `SRB_A_STACK)
         v = `SRB_RST_STACK;
      return v;
   endfunction : plain_reset

   // Slot of a fixed address; used for the registers the logic reads directly.
   function automatic logic [4:0] slot(input logic [7:0] a);
      srb_pkg::srb_hit_t h;
      h = find_plain(a);
      return h.idx;
   endfunction : slot

   localparam logic [4:0] I_B0L = slot(`SRB_A_BANK0_LO);
   localparam logic [4:0] I_B0H = slot(`SRB_A_BANK0_HI);
   localparam logic [4:0] I_B1L = slot(`SRB_A_BANK1_LO);
   localparam logic [4:0] I_B1H = slot(`SRB_A_BANK1_HI);
   localparam logic [4:0] I_SCTRL = slot(`SRB_A_SCTRL);
   localparam logic [4:0] I_IEN = slot(`SRB_A_INT_EN);
   localparam logic [4:0] I_IPRI = slot(`SRB_A_INT_PRI);
   localparam logic [4:0] I_P0 = slot(`SRB_A_PORT0);
   localparam logic [4:0] I_P1 = slot(`SRB_A_PORT1);
   localparam logic [4:0] I_P2 = slot(`SRB_A_PORT2);
   localparam logic [4:0] I_P3 = slot(`SRB_A_PORT3);

   // ==========================================================
   // Reset release

   logic [1:0] rst_sync_q;
   logic [1:0] por_sync_q;
   wire logic rst_n = rst_sync_q[1];
   wire logic por_n = por_sync_q[1];

   // Assertion is immediate, release passes two flops to avoid metastable exits.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   always_ff @(posedge clock_i or negedge por_n_i)
   begin
      if (!por_n_i)
         por_sync_q <= 2'b00;
      else
         por_sync_q <= {por_sync_q[0], 1'b1};
   end

   // ==========================================================
   // Register state

   logic [7:0] plain_q [`SRB_NPLAIN];
   logic [7:0] plain_d [`SRB_NPLAIN];
   srb_pkg::srb_timer_two_control_t timer_two_control_q;
   srb_pkg::srb_timer_two_control_t timer_two_control_d;
   logic [7:0] t2mode_q;
   logic [7:0] power_q;
   logic pof_q;
   logic pof_d;
   logic bank_q;
   logic bank_d;
   logic [`SRB_NEVT-1:0] status_q;
   logic [`SRB_NEVT-1:0] status_d;
   logic [`SRB_NEVT-1:0] mask_q;
   logic [15:0] pointer_q;
   logic [15:0] pointer_d;
   logic [7:0] rdata_q;
   logic [7:0] rd_val;
   logic rx_tick_q;
   logic tx_tick_q;
   logic t2_irq_q;
   logic irq_q;
   logic [$clog2(MCYC_DIV)-1:0] mcyc_q;

   // ==========================================================
   // Address decode

   wire srb_pkg::srb_hit_t hit = find_plain(addr_i);
   wire logic wr_plain = wr_i & hit.hit;
   wire logic wr_timer_two_control = wr_i & (addr_i == `SRB_A_T2_CTRL);
   wire logic wr_t2mode = wr_i & (addr_i == `SRB_A_T2_MODE);
   wire logic wr_power = wr_i & (addr_i == `SRB_A_POWER);
   wire logic wr_aux1 = wr_i & (addr_i == `SRB_A_AUX_ONE);
   wire logic wr_status = wr_i & (addr_i == `SRB_A_EVT_STATUS);
   wire logic wr_mask = wr_i & (addr_i == `SRB_A_EVT_MASK);

   // ==========================================================
   // Third timer

   wire logic mcyc_tick = (mcyc_q == ($clog2(MCYC_DIV))'(MCYC_DIV - 1));
   wire logic [1:0] pin_fall;
   wire logic [15:0] t2_count;
   wire logic [15:0] t2_reload;
   wire srb_pkg::srb_t2evt_t t2_evt;
   wire logic baud = timer_two_control_q.rx_clk_sel | timer_two_control_q.tx_clk_sel;
   wire logic updown = t2mode_q[`SRB_B_UPDOWN];

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         mcyc_q <= '0;
      else
         mcyc_q <= mcyc_tick ? '0 : mcyc_q + 1'b1;
   end

   srb_sync #(
      .W(2)
   ) u_pin_sync (
      .clk_i(clock_i),
      .rst_n_i(rst_n),
      .pin_i({timer_two_trigger_input_i, timer_two_count_input_i}),
      .fall_o(pin_fall)
   );

   srb_timer2 u_timer2 (
      .clk_i(clock_i),
      .rst_n_i(rst_n),
      .cfg_i(timer_two_control_q),
      .mcyc_tick_i(mcyc_tick),
      .cnt_fall_i(pin_fall[0]),
      .trig_fall_i(pin_fall[1]),
      .wr_i(wr_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .count_o(t2_count),
      .reload_o(t2_reload),
      .evt_o(t2_evt)
   );

   wire logic set_ovf = t2_evt.ovf & ~baud;
   wire logic set_ext = t2_evt.ext;

   // ==========================================================
   // Next-state logic

   always_comb
   begin
      plain_d = plain_q;
      if (wr_plain)
         plain_d[hit.idx] = wdata_i;
      // Increment comes after the write, so it acts on freshly written bytes.
      if (pointer_inc_i)
      begin
         if (bank_q)
            {plain_d[I_B1H], plain_d[I_B1L]} = {plain_d[I_B1H], plain_d[I_B1L]} + 16'h0001;
         else
            {plain_d[I_B0H], plain_d[I_B0L]} = {plain_d[I_B0H], plain_d[I_B0L]} + 16'h0001;
      end
   end

   // Hardware sets outrank a software write to the same flag.
   always_comb
   begin
      timer_two_control_d = wr_timer_two_control ? srb_pkg::srb_timer_two_control_t'(wdata_i) : timer_two_control_q;
      timer_two_control_d.ovf_flag = timer_two_control_d.ovf_flag | set_ovf;
      timer_two_control_d.ext_flag = timer_two_control_d.ext_flag | set_ext;
   end

   assign bank_d = wr_aux1 ? wdata_i[`SRB_B_BANK_SEL] : bank_q;
   assign pof_d = wr_power ? wdata_i[`SRB_B_POWER_OFF] : pof_q;
   assign status_d = (status_q & ~(wr_status ? wdata_i[`SRB_NEVT-1:0] : '0))
                     | {set_ext, set_ovf};
   assign pointer_d = bank_d ? {plain_d[I_B1H], plain_d[I_B1L]}
                             : {plain_d[I_B0H], plain_d[I_B0L]};

   // ==========================================================
   // Read multiplexer

   always_comb
   begin
      rd_val = `SRB_RST_ZERO;
      if (hit.hit)
         rd_val = plain_q[hit.idx];
      else
      begin
         unique case (addr_i)
            `SRB_A_T2_CTRL: rd_val = timer_two_control_q;
            `SRB_A_T2_MODE: rd_val = t2mode_q;
            `SRB_A_T2_CAP_LO: rd_val = t2_reload[7:0];
            `SRB_A_T2_CAP_HI: rd_val = t2_reload[15:8];
            `SRB_A_T2_CNT_LO: rd_val = t2_count[7:0];
            `SRB_A_T2_CNT_HI: rd_val = t2_count[15:8];
            `SRB_A_POWER:
            begin
               rd_val = power_q;
               rd_val[`SRB_B_POWER_OFF] = pof_q;
            end
            `SRB_A_AUX_ONE: rd_val[`SRB_B_BANK_SEL] = bank_q;
            `SRB_A_EVT_STATUS: rd_val[`SRB_NEVT-1:0] = status_q;
            `SRB_A_EVT_MASK: rd_val[`SRB_NEVT-1:0] = mask_q;
            default: rd_val = `SRB_RST_ZERO;
         endcase
      end
   end

   // ==========================================================
   // Flip-flops

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `SRB_NPLAIN; i++)
            plain_q[i] <= plain_reset(PLAIN_ADDR[i]);
      end
      else
         plain_q <= plain_d;
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_two_control_q <= srb_pkg::srb_timer_two_control_t'(`SRB_RST_ZERO);
         t2mode_q <= `SRB_RST_ZERO;
         power_q <= `SRB_RST_ZERO;
         bank_q <= 1'b0;
         status_q <= '0;
         mask_q <= '0;
         pointer_q <= 16'h0000;
      end
      else
      begin
         timer_two_control_q <= timer_two_control_d;
         t2mode_q <= wr_t2mode ? (wdata_i & `SRB_T2_MODE_MASK) : t2mode_q;
         power_q <= wr_power ? (wdata_i & `SRB_POWER_MASK) : power_q;
         bank_q <= bank_d;
         status_q <= status_d;
         mask_q <= wr_mask ? wdata_i[`SRB_NEVT-1:0] : mask_q;
         pointer_q <= pointer_d;
      end
   end

   // The power-off flag sees only the power-up reset, never the system reset.
   always_ff @(posedge clock_i or negedge por_n)
   begin
      if (!por_n)
         pof_q <= 1'b1;
      else
         pof_q <= pof_d;
   end

   // ==========================================================
   // Registered outputs

   wire logic ser_mode13 = plain_q[I_SCTRL][`SRB_B_SER_MODE13];
   wire logic t2_req = timer_two_control_d.ovf_flag | (timer_two_control_d.ext_flag & ~updown);

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= `SRB_RST_ZERO;
         rx_tick_q <= 1'b0;
         tx_tick_q <= 1'b0;
         t2_irq_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rd_i ? rd_val : `SRB_RST_ZERO;
         rx_tick_q <= ser_mode13 & (timer_two_control_q.rx_clk_sel ? t2_evt.ovf : timer_one_ovf_i);
         tx_tick_q <= ser_mode13 & (timer_two_control_q.tx_clk_sel ? t2_evt.ovf : timer_one_ovf_i);
         t2_irq_q <= plain_d[I_IEN][`SRB_B_EN_TMR2] & t2_req;
         irq_q <= |(status_d & (wr_mask ? wdata_i[`SRB_NEVT-1:0] : mask_q));
      end
   end

   assign rdata_o = rdata_q;
   assign pointer_o = pointer_q;
   assign port_latch_o = {plain_q[I_P3], plain_q[I_P2], plain_q[I_P1], plain_q[I_P0]};
   assign int_enable_o = plain_q[I_IEN];
   assign int_priority_o = plain_q[I_IPRI];
   assign power_off_flag_o = pof_q;
   assign rx_baud_tick_o = rx_tick_q;
   assign tx_baud_tick_o = tx_tick_q;
   assign timer_two_irq_o = t2_irq_q;
   assign irq_o = irq_q;

endmodule : srb_top
`default_nettype wire

// File: testbench/srb_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port-level checker for the register bank
module srb_top_sva (
   // Clock and resets
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic por_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Observed outputs
   input wire logic [31:0] port_latch_o,
   input wire logic [7:0] int_enable_o,
   input wire logic [7:0] int_priority_o,
   input wire logic power_off_flag_o,
   input wire logic tx_baud_tick_o,
   input wire logic timer_two_irq_o
);
   a_read_idle_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data present without a read");
   a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_i && (addr_i == 8'hFF || addr_i == 8'hC0) |=> rdata_o == 8'h00)
      else $error("unmapped read returned nonzero");
   // Only the power-up reset may move the flag, so the system reset is not a disable here.
   a_pof_reset_proof: assert property (@(posedge clock_i) disable iff (!por_n_i)
      !(wr_i && addr_i == 8'h87) ##1 !(wr_i && addr_i == 8'h87) |=> $stable(power_off_flag_o))
      else $error("power-off flag changed without a write");
   a_t2irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !int_enable_o[5] ##1 !int_enable_o[5] |-> !timer_two_irq_o)
      else $error("timer interrupt while disabled");
   a_enable_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_i && addr_i == 8'hA8 |=> int_enable_o == $past(wdata_i))
      else $error("enable register not written");
   a_priority_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_i && addr_i == 8'hB8 |=> int_priority_o == $past(wdata_i))
      else $error("priority register not written");
   a_port_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      wr_i && addr_i == 8'h80 |=> port_latch_o[7:0] == $past(wdata_i))
      else $error("port latch not written");
   a_tick_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      tx_baud_tick_o |=> !tx_baud_tick_o)
      else $error("transmit tick longer than one cycle");
endmodule : srb_top_sva

bind srb_top srb_top_sva srb_top_sva_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .port_latch_o(port_latch_o), .int_enable_o(int_enable_o), .int_priority_o(int_priority_o),
   .power_off_flag_o(power_off_flag_o), .tx_baud_tick_o(tx_baud_tick_o),
   .timer_two_irq_o(timer_two_irq_o));
`default_nettype wire

// File: testbench/srb_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Core-side register master
module srb_core_model (
   // Clock
   input wire logic clock_i,
   // Register port
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // The port never stalls, so each strobe lasts exactly one edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clock_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      // Read data stand for the whole next cycle; take them at its closing edge.
      @(posedge clock_i);
      d = rdata_i;
   endtask : rd
endmodule : srb_core_model
`default_nettype wire

// File: testbench/tb_srb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_srb_top;
   localparam int MDIV = 4;
   localparam logic [15:0] RV [0:23] = '{16'h80FF, 16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8500,
      16'h8710, 16'h8800, 16'h8900, 16'h8A00, 16'h90FF, 16'h9800, 16'hA0FF, 16'hA200, 16'hA800,
      16'hB0FF, 16'hB800, 16'hC800, 16'hC900, 16'hCA00, 16'hCD00, 16'hE000, 16'hF000, 16'hFF00};
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic por_n_i = 1'b0;
   logic inc = 1'b0;
   logic t1_ovf = 1'b0;
   logic cnt_pin = 1'b1;
   logic trig_pin = 1'b1;
   logic wr, rd, power_off_flag, rx_tick, tx_tick, t2_irq, irq;
   logic [7:0] addr, wdata, rdata, ie, ip;
   logic [15:0] pointer, v0, v1;
   logic [31:0] ports, r, seed = 32'h00000017;
   logic [31:0] eports = 32'hFFFFFFFF;
   int errors = 0;
   int total_checks = 0;
   int rx_n = 0;
   int tx_n = 0;
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i)
   begin
      rx_n <= rx_n + ((rx_tick === 1'b1) ? 1 : 0);
      tx_n <= tx_n + ((tx_tick === 1'b1) ? 1 : 0);
   end
   srb_top #(.MCYC_DIV(MDIV)) srb_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pointer_inc_i(inc),
      .timer_one_ovf_i(t1_ovf), .pointer_o(pointer), .port_latch_o(ports), .int_enable_o(ie),
      .int_priority_o(ip), .power_off_flag_o(power_off_flag), .timer_two_count_input_i(cnt_pin),
      .timer_two_trigger_input_i(trig_pin), .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick),
      .timer_two_irq_o(t2_irq), .irq_o(irq));
   srb_core_model srb_core_model_i (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .rdata_i(rdata));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t register read %h, expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t output %h, expected %h", $time, got, exp);
      end
   endtask : chk_pin
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      srb_core_model_i.wr(a, d);
   endtask : w
   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      w(a, v[7:0]);
      w(a + 8'h01, v[15:8]);
   endtask : w16
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      srb_core_model_i.rd(a, d);
      chk_reg(d, e);
   endtask : rc
   task automatic rc16(input logic [7:0] a, input logic [15:0] v);
      rc(a, v[7:0]);
      rc(a + 8'h01, v[15:8]);
   endtask : rc16
   // Pins are held low long enough to pass the three-flop synchroniser.
   task automatic pulse(input int which);
      @(posedge clock_i);
      cnt_pin <= (which == 0) ? 1'b0 : 1'b1;
      trig_pin <= (which == 1) ? 1'b0 : 1'b1;
      t1_ovf <= (which == 2);
      inc <= (which == 3);
      @(posedge clock_i);
      t1_ovf <= 1'b0;
      inc <= 1'b0;
      repeat (3) @(posedge clock_i);
      cnt_pin <= 1'b1;
      trig_pin <= 1'b1;
      repeat (8) @(posedge clock_i);
   endtask : pulse
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   initial
   begin
      #200000;
      errors++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      por_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      foreach (RV[k]) rc(RV[k][15:8], RV[k][7:0]);
      chk_pin(ports, 32'hFFFFFFFF);
      chk_pin(power_off_flag, 1'b1);
      w(8'hFF, 8'h00);
      rc(8'hFF, 8'h00);
      done("reset");
      for (int k = 0; k < 4; k++)
      begin
         r = rnd();
         w(8'h80 + 8'(k * 16), r[7:0]);
         eports[k*8 +: 8] = r[7:0];
      end
      r = rnd();
      w(8'hA8, r[7:0]);
      w(8'hB8, r[15:8]);
      rc(8'hA8, r[7:0]);
      rc(8'hB8, r[15:8]);
      chk_pin(ports, eports);
      chk_pin({ip, ie}, r[15:0]);
      done("ports");
      for (int k = 0; k < 2; k++)
      begin
         r = rnd();
         v0 = r[15:0];
         v1 = r[31:16];
         w16(8'h82, v0);
         w16(8'h84, v1);
         w(8'hA2, 8'h00);
         repeat (2) @(posedge clock_i);
         chk_pin(pointer, v0);
         w(8'hA2, 8'h01);
         repeat (2) @(posedge clock_i);
         chk_pin(pointer, v1);
         pulse(3);
         v1 = v1 + 16'h0001;
         chk_pin(pointer, v1);
         rc16(8'h84, v1);
         rc16(8'h82, v0);
      end
      w(8'hA2, 8'h00);
      pulse(3);
      chk_pin(pointer, 16'(v0 + 16'h0001));
      done("pointers");
      w(8'h87, 8'h00);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk_pin(ports, 32'hFFFFFFFF);
      chk_pin(power_off_flag, 1'b0);
      rc(8'h87, 8'h00);
      rc(8'h84, 8'h00);
      w(8'h87, 8'h10);
      rc(8'h87, 8'h10);
      done("power flag");
      r = rnd();
      w16(8'hCA, r[15:0]);
      w16(8'hCC, 16'hFFFF);
      w(8'hF8, 8'h03);
      w(8'hC8, 8'h02);
      pulse(0);
      rc16(8'hCC, 16'hFFFF);
      w(8'hC8, 8'h06);
      pulse(0);
      rc16(8'hCC, r[15:0]);
      rc(8'hC8, 8'h86);
      rc(8'hF8, 8'h01);
      pulse(0);
      rc16(8'hCC, r[15:0] + 16'h0001);
      w(8'hA8, 8'h20);
      w(8'hF9, 8'h01);
      repeat (3) @(posedge clock_i);
      chk_pin({t2_irq, irq}, 2'b11);
      w(8'hF9, 8'h00);
      repeat (3) @(posedge clock_i);
      chk_pin(irq, 1'b0);
      w(8'hF9, 8'h01);
      w(8'hF8, 8'h01);
      w(8'hC8, 8'h40);
      repeat (3) @(posedge clock_i);
      chk_pin({t2_irq, irq}, 2'b10);
      w(8'hC9, 8'h01);
      repeat (3) @(posedge clock_i);
      chk_pin(t2_irq, 1'b0);
      w(8'hC9, 8'h00);
      w(8'hC8, 8'h00);
      w16(8'hCC, 16'hFFFF);
      w(8'hC8, 8'h04);
      repeat (14) @(posedge clock_i);
      rc(8'hC8, 8'h84);
      done("timer");
      r = rnd();
      w(8'hC8, 8'h0B);
      w16(8'hCC, r[15:0]);
      pulse(1);
      rc16(8'hCA, r[15:0]);
      rc(8'hC8, 8'h4B);
      rc(8'hF8, 8'h03);
      w(8'hC8, 8'h0A);
      w16(8'hCA, r[31:16]);
      pulse(1);
      rc16(8'hCC, r[31:16]);
      w(8'hC8, 8'h02);
      w16(8'hCC, r[15:0]);
      pulse(1);
      rc16(8'hCC, r[15:0]);
      rc(8'hC8, 8'h02);
      done("trigger");
      w(8'h98, 8'h40);
      w16(8'hCC, 16'hFFFF);
      w(8'hC8, 8'h3F);
      pulse(1);
      rc16(8'hCC, 16'hFFFF);
      v0 = 16'(rx_n);
      v1 = 16'(tx_n);
      pulse(0);
      rc16(8'hCC, r[31:16]);
      rc(8'hC8, 8'h3F);
      chk_pin({16'(rx_n) - v0, 16'(tx_n) - v1}, 32'h00010001);
      w(8'hC8, 8'h00);
      pulse(2);
      chk_pin({16'(rx_n) - v0, 16'(tx_n) - v1}, 32'h00020002);
      done("baud");
      conclude();
   end
endmodule : tb_srb_top
`default_nettype wire
